// >>> common/dsa_pkg.sv
//==============================================================
// Operation
// - non-mac ops see whole range as X
// - mac reads use fixed pointer pairs concurrently
// - all writes go over X write bus
// - accumulator write-back targets any address
// - bit-reverse X writes only; fixed boundary
// - unimplemented address reads return zero
// - mac X pointer into Y returns zero
// - mac Y pointer into X returns zero
// - 16-bit byte addresses, two byte lanes
// - byte read selects lane onto low byte
// - Y path fetches words only
// - byte write enables matching lane only
// - pointer step one for byte, two word
// - odd word access traps; write suppressed
// - byte load keeps register high byte
// - near region 0x0000-0x1FFF decoded
// - stack grows up; push post, pop pre
// - call zero-extends pc msb; exception adds status
// - stack limit bit 0 reads zero
// - push beyond stack limit traps
// - stack pointer below 0x0800 traps
package dsa_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 16;
  // register map on the plain port
  localparam logic [1:0]  REG_LIMIT    = 2'h0;
  localparam logic [1:0]  REG_STATUS   = 2'h1;
  localparam logic [1:0]  REG_YSPACE   = 2'h2;
  // status field positions
  localparam int          ST_ADDR_ERR  = 0;
  localparam int          ST_STK_ERR   = 1;
  localparam int          ST_UNDERFLOW = 2;
  // fixed space boundaries, limit reset value and pointer steps
  localparam logic [15:0] Y_BASE       = 16'h0800;
  localparam logic [15:0] Y_END        = 16'h0FFF;
  localparam logic [15:0] RAM_END      = 16'h0FFF;
  localparam logic [15:0] NEAR_END     = 16'h1FFF;
  localparam logic [15:0] STACK_FLOOR  = 16'h0800;
  localparam logic [15:0] LIMIT_RESET  = 16'h0000;
  localparam logic [15:0] STEP_BYTE    = 16'h0001;
  localparam logic [15:0] STEP_WORD    = 16'h0002;
endpackage

// >>> rtl/data_space_access_unit.sv
`timescale 1ns/10ps
module data_space_access_unit
  import dsa_pkg::*;
#(
  parameter logic [15:0] Y_LO     = Y_BASE,    // first Y byte
  parameter logic [15:0] Y_HI     = Y_END,     // last Y byte
  parameter logic [15:0] MEM_TOP  = RAM_END    // last implemented byte
)(
  input  wire logic        core_clk,         // 40 MHz core clock
  input  wire logic        rst,              // async reset, high
  // register port
  input  wire logic [1:0]  reg_addr,         // register index
  input  wire logic [15:0] reg_wdata,        // write data
  input  wire logic        reg_wr,           // write strobe
  input  wire logic        reg_rd,           // read strobe
  output logic      [15:0] reg_rdata,        // read data, next cycle
  // X access request from core
  input  wire logic        x_req,            // X access valid
  input  wire logic        x_write,          // 1 write, 0 read
  input  wire logic        x_byte,           // byte sized
  input  wire logic        x_mac,            // mac prefetch read
  input  wire logic        x_bitrev,         // bit-reversed address used
  input  wire logic [15:0] x_addr,           // effective byte address
  input  wire logic [15:0] x_wdata,          // write data
  // Y prefetch request
  input  wire logic        y_req,            // Y mac prefetch valid
  input  wire logic [15:0] y_addr,           // y pointer address
  // memory side
  output logic      [14:0] mem_x_addr,       // X word address
  output logic             mem_x_rd,         // X read strobe
  output logic      [1:0]  mem_x_we,         // byte lane write enables
  output logic      [15:0] mem_x_wdata,      // write data
  output logic      [14:0] mem_y_addr,       // Y word address
  output logic             mem_y_rd,         // Y read strobe
  input  wire logic [15:0] mem_x_rdata,      // X word, same cycle as rd
  input  wire logic [15:0] mem_y_rdata,      // Y word, same cycle as rd
  // returned data
  output logic      [15:0] x_rdata,          // X read result
  output logic      [15:0] y_rdata,          // Y read result
  output logic             rdata_vld,        // results valid
  // register-file byte merge
  input  wire logic [15:0] wreg_old,         // destination register now
  output logic      [15:0] wreg_new,         // merged register value
  // pointer arithmetic
  input  wire logic [15:0] ptr_in,           // pointer before modify
  input  wire logic        ptr_dec,          // decrement instead
  output logic      [15:0] ptr_out,          // pointer after modify
  // stack
  input  wire logic        push,             // push request
  input  wire logic        pop,              // pop request
  input  wire logic [15:0] sp_in,            // stack_pointer_reg now
  input  wire logic [15:0] push_data,        // word to push
  input  wire logic        pc_push,          // pushing pc msb word
  input  wire logic        pc_exc,           // exception push
  input  wire logic [7:0]  status_low_byte,  // status low byte
  output logic      [15:0] stack_addr,       // ea of the access
  output logic      [15:0] stack_wdata,      // formatted push word
  output logic      [15:0] sp_next,          // updated pointer
  // near decode and traps
  output logic             near_hit,         // address in near region
  output logic             addr_err_trap,    // misaligned access
  output logic             stack_err_trap    // stack limit or underflow
);

  //==============================================================
  // address decode
  function automatic logic in_y(input logic [15:0] a);
    in_y = (a >= Y_LO) && (a <= Y_HI);
  endfunction

  logic [15:0] limit_q;
  logic [2:0]  sticky_q;
  logic        y_en_q;
  logic        byte_sel_q, byte_q, zero_x_q, zero_y_q;

  // mac X reads exclude Y; other ops see everything as X
  wire x_in_y      = in_y(x_addr) && y_en_q;
  wire x_unimpl    = (x_addr > MEM_TOP);
  wire x_misalign  = !x_byte && x_addr[0];
  wire x_zero      = x_unimpl || (x_mac && !x_write && x_in_y);
  // Y pointers reach only Y; odd bit dropped, words only
  wire y_zero      = !in_y(y_addr) || !y_en_q;
  // bit-reversal is only honoured on writes
  wire x_ok        = x_req && !(x_bitrev && !x_write);
  wire wr_go       = x_ok && x_write && !x_misalign && !x_unimpl;
  wire [1:0] lanes = x_byte ? (x_addr[0] ? 2'b10 : 2'b01) : 2'b11;

  //==============================================================
  // stack checks
  wire [15:0] limit_rd  = {limit_q[15:1], 1'b0};
  wire [15:0] sp_pop    = sp_in - STEP_WORD;
  wire [15:0] s_ea      = pop ? sp_pop : sp_in;
  wire        over      = push && (sp_in > limit_rd);
  wire        under     = (push || pop) && (s_ea < STACK_FLOOR);
  wire [7:0]  pc_msb    = pc_exc ? status_low_byte : 8'h00;
  wire [15:0] push_word = pc_push ? {pc_msb, push_data[7:0]} : push_data;

  //==============================================================
  // register port
  wire [15:0] rd_mux = (reg_addr == REG_LIMIT)  ? limit_rd :
                       (reg_addr == REG_STATUS) ? {13'h0000, sticky_q} :
                       (reg_addr == REG_YSPACE) ? {15'h0000, y_en_q} : 16'h0000;
  wire [2:0] ev = {under, over, x_req && x_misalign};
  // set wins over write-one-to-clear
  wire [2:0] clr = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[2:0] : 3'b000;

  wire [7:0]  sel_byte = byte_sel_q ? mem_x_rdata[15:8] : mem_x_rdata[7:0];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      limit_q  <= LIMIT_RESET;
      sticky_q <= 3'b000;
      y_en_q   <= 1'b1;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      if (reg_wr && reg_addr == REG_LIMIT)
        limit_q <= reg_wdata;
      if (reg_wr && reg_addr == REG_YSPACE)
        y_en_q <= reg_wdata[0];
      sticky_q  <= (sticky_q & ~clr) | ev;
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  //==============================================================
  // memory strobes and returned data
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_x_addr <= 15'h0000;
      mem_x_rd   <= 1'b0;
      mem_x_we   <= 2'b00;
      mem_x_wdata <= 16'h0000;
      mem_y_addr <= 15'h0000;
      mem_y_rd   <= 1'b0;
      byte_sel_q <= 1'b0;
      byte_q     <= 1'b0;
      zero_x_q   <= 1'b0;
      zero_y_q   <= 1'b0;
      rdata_vld  <= 1'b0;
      x_rdata    <= 16'h0000;
      y_rdata    <= 16'h0000;
    end
    else
    begin
      mem_x_addr  <= x_addr[15:1];
      mem_x_rd    <= x_ok && !x_write;
      mem_x_we    <= wr_go ? lanes : 2'b00;
      mem_x_wdata <= x_byte ? {x_wdata[7:0], x_wdata[7:0]} : x_wdata;
      mem_y_addr  <= y_addr[15:1];
      mem_y_rd    <= y_req && x_mac;
      byte_sel_q  <= x_addr[0];
      byte_q      <= x_byte;
      zero_x_q    <= x_zero;
      zero_y_q    <= y_zero;
      rdata_vld   <= mem_x_rd || mem_y_rd;
      x_rdata     <= 16'h0000;
      y_rdata     <= 16'h0000;
      if (mem_x_rd && !zero_x_q)
        x_rdata <= byte_q ? {8'h00, sel_byte} : mem_x_rdata;
      if (mem_y_rd && !zero_y_q)
        y_rdata <= mem_y_rdata;
    end
  end

  //==============================================================
  // core-side results
  wire [15:0] step = x_byte ? STEP_BYTE : STEP_WORD;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wreg_new       <= 16'h0000;
      ptr_out        <= 16'h0000;
      stack_addr     <= 16'h0000;
      stack_wdata    <= 16'h0000;
      sp_next        <= 16'h0000;
      near_hit       <= 1'b0;
      addr_err_trap  <= 1'b0;
      stack_err_trap <= 1'b0;
    end
    else
    begin
      wreg_new       <= x_byte ? {wreg_old[15:8], x_rdata[7:0]} : x_rdata;
      ptr_out        <= ptr_dec ? ptr_in - step : ptr_in + step;
      stack_addr     <= s_ea;
      stack_wdata    <= push_word;
      sp_next        <= push ? sp_in + STEP_WORD : (pop ? sp_pop : sp_in);
      near_hit       <= x_req && (x_addr <= NEAR_END);
      addr_err_trap  <= x_req && x_misalign;
      stack_err_trap <= over || under;
    end
  end

  //==============================================================
  // checks
  // reset sits in each antecedent that $past looks back from, except in a_limit_bit0, so the release
  // edge never compares against a value taken while the flops were held
  a_misalign_no_write: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && x_write && x_misalign) |=> (mem_x_we == 2'h0 && addr_err_trap))
    else $error("misaligned write not suppressed");
  a_misalign_flag: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && !x_byte && x_addr[0]) |=> addr_err_trap)
    else $error("odd word access not flagged");
  a_byte_one_lane: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && x_write && x_byte && !x_unimpl && !x_bitrev && !rst)
      |=> (mem_x_we == ($past(x_addr[0]) ? 2'h2 : 2'h1)))
    else $error("byte write lane wrong");
  a_word_lanes: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && x_write && !x_byte && !x_misalign && !x_unimpl) |=> (mem_x_we == 2'h3))
    else $error("word write lanes wrong");
  a_bitrev_read: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && x_bitrev && !x_write) |=> !mem_x_rd)
    else $error("bit-reversed read issued");
  a_y_mac_only: assert property (@(posedge core_clk) disable iff (rst)
    !(y_req && x_mac) |=> !mem_y_rd)
    else $error("Y read outside mac");
  a_mac_x_zero: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && x_mac && !x_write && x_in_y) |=> ##1 (x_rdata == 16'h0000))
    else $error("mac X fetch into Y not zero");
  a_mac_y_zero: assert property (@(posedge core_clk) disable iff (rst)
    (y_req && x_mac && !in_y(y_addr)) |=> ##1 (y_rdata == 16'h0000))
    else $error("mac Y fetch into X not zero");
  a_unimpl_zero: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && !x_write && x_unimpl) |=> ##1 (x_rdata == 16'h0000))
    else $error("unimplemented read not zero");
  a_byte_read_low: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && x_byte && !x_write && !x_bitrev) |=> ##1 (x_rdata[15:8] == 8'h00))
    else $error("byte read high byte not zero");
  a_byte_keep_high: assert property (@(posedge core_clk) disable iff (rst)
    (x_byte && !rst) |=> (wreg_new[15:8] == $past(wreg_old[15:8])))
    else $error("byte load touched high byte");
  a_limit_bit0: assert property (@(posedge core_clk) disable iff (rst)
    $past(reg_rd && reg_addr == REG_LIMIT) |-> (reg_rdata[0] == 1'b0))
    else $error("limit bit 0 not zero");
  a_push_at_limit: assert property (@(posedge core_clk) disable iff (rst)
    (push && sp_in == limit_rd && sp_in >= STACK_FLOOR) |=> !stack_err_trap)
    else $error("push at limit trapped");
  a_push_over: assert property (@(posedge core_clk) disable iff (rst)
    (push && sp_in > limit_rd) |=> stack_err_trap)
    else $error("push beyond limit not trapped");
  a_underflow_trap: assert property (@(posedge core_clk) disable iff (rst)
    (pop && sp_pop < STACK_FLOOR) |=> stack_err_trap)
    else $error("underflow not trapped");
  a_sp_push_step: assert property (@(posedge core_clk) disable iff (rst)
    (push && !pop && !rst) |=> (sp_next == $past(sp_in) + STEP_WORD))
    else $error("push did not post-increment");
  a_pc_zero_ext: assert property (@(posedge core_clk) disable iff (rst)
    (pc_push && !pc_exc && !rst) |=> (stack_wdata[15:8] == 8'h00))
    else $error("call push msb not zero");
  a_pc_status: assert property (@(posedge core_clk) disable iff (rst)
    (pc_push && pc_exc && !rst) |=> (stack_wdata[15:8] == $past(status_low_byte)))
    else $error("exception push msb not status");
  a_near_decode: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && x_addr == 16'h2000) |=> !near_hit)
    else $error("near decode too wide");
  a_near_hit: assert property (@(posedge core_clk) disable iff (rst)
    (x_req && x_addr <= NEAR_END) |=> near_hit)
    else $error("near address missed");
  a_step_size: assert property (@(posedge core_clk) disable iff (rst)
    (!ptr_dec && !rst)
      |=> (ptr_out == $past(ptr_in) + ($past(x_byte) ? STEP_BYTE : STEP_WORD)))
    else $error("pointer step wrong");
  a_step_down: assert property (@(posedge core_clk) disable iff (rst)
    (ptr_dec && !rst)
      |=> (ptr_out == $past(ptr_in) - ($past(x_byte) ? STEP_BYTE : STEP_WORD)))
    else $error("pointer decrement wrong");

endmodule

// >>> dv/data_mem_model.sv
`timescale 1ns/10ps
// ==========================================================
// word memory behind the access unit, two byte lanes
module data_mem_model
  import dsa_pkg::*;
(
  input  wire logic        core_clk,     // core clock
  input  wire logic [14:0] mem_x_addr,   // X word address
  input  wire logic        mem_x_rd,     // X read strobe
  input  wire logic [1:0]  mem_x_we,     // lane write enables
  input  wire logic [15:0] mem_x_wdata,  // write data
  input  wire logic [14:0] mem_y_addr,   // Y word address
  input  wire logic        mem_y_rd,     // Y read strobe
  output logic      [15:0] mem_x_rdata,  // X word
  output logic      [15:0] mem_y_rdata   // Y word
);
  logic [15:0] mem [0:2047];
  // word follows the strobed address in the strobe's own cycle; the unit registers it
  // idle bus shows the inverted word so stale data never passes for a fetch
  assign mem_x_rdata = mem_x_rd ? mem[mem_x_addr[10:0]] : ~mem[mem_x_addr[10:0]];
  assign mem_y_rdata = mem_y_rd ? mem[mem_y_addr[10:0]] : ~mem[mem_y_addr[10:0]];
  always @(posedge core_clk)
  begin
    if (mem_x_we[0]) mem[mem_x_addr[10:0]][7:0] <= mem_x_wdata[7:0];
    if (mem_x_we[1]) mem[mem_x_addr[10:0]][15:8] <= mem_x_wdata[15:8];
  end
endmodule

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb
  import dsa_pkg::*;
;
  logic        core_clk, rst, reg_wr, reg_rd, x_req, x_write, x_byte, x_mac, x_bitrev;
  logic        y_req, ptr_dec, push, pop, pc_push, pc_exc, mem_x_rd, mem_y_rd, rdata_vld;
  logic        near_hit, addr_err_trap, stack_err_trap, near_s, err_s;
  logic [1:0]  reg_addr, mem_x_we, we_s;
  logic [7:0]  status_low_byte;
  logic [14:0] mem_x_addr, mem_y_addr;
  logic [15:0] reg_wdata, reg_rdata, x_addr, x_wdata, y_addr, mem_x_wdata, mem_x_rdata;
  logic [15:0] mem_y_rdata, x_rdata, y_rdata, wreg_old, wreg_new, ptr_in, ptr_out, ptr_s;
  logic [15:0] sp_in, push_data, stack_addr, stack_wdata, sp_next;
  int          failures, check_count, i;
  typedef struct packed {logic [15:0] a; logic b; logic dc; logic [15:0] p; logic nr;
    logic er;} row_s;
  row_s rows [5] = '{'{16'h0100, 1'b0, 1'b0, 16'h0102, 1'b1, 1'b0},
    '{16'h0101, 1'b1, 1'b0, 16'h0102, 1'b1, 1'b0}, '{16'h0101, 1'b0, 1'b1, 16'h00FF, 1'b1, 1'b1},
    '{16'h1FFE, 1'b0, 1'b1, 16'h1FFC, 1'b1, 1'b0}, '{16'h2000, 1'b1, 1'b0, 16'h2001, 1'b0, 1'b0}};

  data_space_access_unit u_dut (.*);
  data_mem_model         u_mem (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic x_op(input logic w, b, m, yq, dc, input logic [15:0] a, d, ya);
    int n;
    @(posedge core_clk);
    {x_req, x_write, x_byte, x_mac, y_req, ptr_dec} <= {1'b1, w, b, m, yq, dc};
    {x_addr, ptr_in, x_wdata, y_addr} <= {a, a, d, ya};
    @(posedge core_clk);
    x_req <= 1'b0;
    y_req <= 1'b0;
    #1 {we_s, near_s, err_s, ptr_s} = {mem_x_we, near_hit, addr_err_trap, ptr_out};
    // reads only: wait for the returned word under a bound
    for (n = 0; !w && n < 6 && rdata_vld !== 1'b1; n++) #25;
    if (!w && rdata_vld !== 1'b1)
    begin
      failures++;
      finish_test();
    end
  endtask
  task automatic stk(input logic ps, pp, pc, ex, input logic [15:0] sp, ea, wd, nx,
    input logic tr);
    @(posedge core_clk);
    {push, pop, pc_push, pc_exc, sp_in} <= {ps, pp, pc, ex, sp};
    @(posedge core_clk);
    push <= 1'b0;
    pop <= 1'b0;
    #1 chk("stack_addr", ea, stack_addr);
    if (ps) chk("stack_wdata", wd, stack_wdata);
    chk("sp_next", nx, sp_next);
    chk("stack_err", 16'(tr), 16'(stack_err_trap));
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {reg_wr, reg_rd, x_req, x_write, x_byte, x_mac, x_bitrev, y_req} = '0;
    {ptr_dec, push, pop, pc_push, pc_exc, reg_addr, reg_wdata, x_addr, x_wdata} = '0;
    {y_addr, ptr_in, sp_in} = '0;
    {wreg_old, push_data, status_low_byte} = {16'hBEEF, 16'h12AB, 8'h5C};
    {failures, check_count} = '0;
    rst = 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++)
    begin
      x_op(1'b0, rows[i].b, 1'b0, 1'b0, rows[i].dc, rows[i].a, 16'h0000, 16'h0000);
      chk("ptr_out", rows[i].p, ptr_s);
      chk("near_hit", 16'(rows[i].nr), 16'(near_s));
      chk("addr_err", 16'(rows[i].er), 16'(err_s));
    end
    $display("pointer table done");
    rd_reg(REG_LIMIT, 16'h0000);
    wr_reg(REG_LIMIT, 16'h1FFF);
    rd_reg(REG_LIMIT, 16'h1FFE);
    rd_reg(2'h3, 16'h0000);
    $display("register test done");
    x_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0100, 16'hA5C3, 16'h0000);
    chk("mem_x_we", 16'h0003, 16'(we_s));
    x_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0101, 16'h007E, 16'h0000);
    chk("mem_x_we", 16'h0002, 16'(we_s));
    x_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0802, 16'h3C5A, 16'h0000);
    chk("mem_x_we", 16'h0003, 16'(we_s));
    x_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0103, 16'hFFFF, 16'h0000);
    chk("mem_x_we", 16'h0000, 16'(we_s));
    chk("addr_err", 16'h0001, 16'(err_s));
    x_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0000, 16'h0000);
    chk("x_rdata", 16'h7EC3, x_rdata);
    x_op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0101, 16'h0000, 16'h0000);
    chk("x_rdata", 16'h007E, x_rdata);
    #25 chk("wreg_new", 16'hBE7E, wreg_new);
    x_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0802, 16'h0000, 16'h0000);
    chk("x_rdata", 16'h3C5A, x_rdata);
    x_op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0100, 16'h0000, 16'h0802);
    chk("x_rdata", 16'h7EC3, x_rdata);
    chk("y_rdata", 16'h3C5A, y_rdata);
    x_op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0802, 16'h0000, 16'h0100);
    chk("x_rdata", 16'h0000, x_rdata);
    chk("y_rdata", 16'h0000, y_rdata);
    x_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h2000, 16'h0000, 16'h0000);
    chk("x_rdata", 16'h0000, x_rdata);
    wr_reg(REG_YSPACE, 16'h0000);
    x_op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0802, 16'h0000, 16'h0802);
    chk("x_rdata", 16'h3C5A, x_rdata);
    chk("y_rdata", 16'h0000, y_rdata);
    wr_reg(REG_YSPACE, 16'h0001);
    @(posedge core_clk);
    x_bitrev <= 1'b1;
    x_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0104, 16'h1234, 16'h0000);
    chk("mem_x_we", 16'h0003, 16'(we_s));
    @(posedge core_clk);
    {x_req, x_write} <= 2'h2;
    @(posedge core_clk);
    {x_req, x_bitrev} <= 2'h0;
    #1 chk("mem_x_rd", 16'h0000, 16'(mem_x_rd));
    x_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0104, 16'h0000, 16'h0000);
    chk("x_rdata", 16'h1234, x_rdata);
    $display("access test done");
    stk(1'b1, 1'b0, 1'b0, 1'b0, 16'h1FFE, 16'h1FFE, 16'h12AB, 16'h2000, 1'b0);
    stk(1'b1, 1'b0, 1'b0, 1'b0, 16'h2000, 16'h2000, 16'h12AB, 16'h2002, 1'b1);
    stk(1'b0, 1'b1, 1'b0, 1'b0, 16'h0802, 16'h0800, 16'h0000, 16'h0800, 1'b0);
    stk(1'b0, 1'b1, 1'b0, 1'b0, 16'h0800, 16'h07FE, 16'h0000, 16'h07FE, 1'b1);
    stk(1'b1, 1'b0, 1'b1, 1'b0, 16'h0F00, 16'h0F00, 16'h00AB, 16'h0F02, 1'b0);
    stk(1'b1, 1'b0, 1'b1, 1'b1, 16'h0F00, 16'h0F00, 16'h5CAB, 16'h0F02, 1'b0);
    $display("stack test done");
    rd_reg(REG_STATUS, 16'h0007);
    wr_reg(REG_STATUS, 16'h0007);
    rd_reg(REG_STATUS, 16'h0000);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1 chk("sp_next", 16'h0000, sp_next);
    rd_reg(REG_LIMIT, 16'h0000);
    rd_reg(REG_YSPACE, 16'h0001);
    $display("reset test done");
    finish_test();
  end
endmodule
